// ---- shared/slp_pkg.sv ----
// constants, register map and state codes for the serial lane port allocator
package slp_pkg;
   localparam int NUM_LANES      = 5;           // lanes each direction
   localparam int PRIM_MAX_LANES = 4;           // primary port ceiling
   localparam int SEC_MAX_LANES  = 2;           // secondary port ceiling
   localparam int LANE_BITS      = 8;           // data bits per lane
   localparam int CLK_HZ         = 10_000_000;  // core_clk rate
   localparam int TX_HALF_NS     = 400;         // lane clock half period, full rate
   localparam int TX_HALF_CYC    = TX_HALF_NS * (CLK_HZ / 1_000_000) / 1000;
   localparam int INIT_US        = 10;          // initialization stage length
   localparam int TRAIN_INIT_CYC = INIT_US * (CLK_HZ / 1_000_000);
   localparam int TIMEOUT_US     = 2000;        // calibration give-up time
   localparam int TRAIN_TIMEOUT_CYC = TIMEOUT_US * (CLK_HZ / 1_000_000);
   localparam logic [3:0] BITCAL_EDGES  = 4'h8; // clock edges proving a lane
   localparam logic [7:0] TRAIN_PATTERN = 8'ha5;
   localparam logic [7:0] IDLE_BYTE     = 8'h00;
   // register word addresses
   localparam logic [3:0] ADDR_CTRL   = 4'h0;
   localparam logic [3:0] ADDR_STATUS = 4'h1;
   localparam logic [3:0] ADDR_ALLOC  = 4'h2;
   localparam logic [3:0] ADDR_ERR    = 4'h3;
   // field positions
   localparam int CTRL_COH_BIT   = 0;
   localparam int CTRL_HALF_BIT  = 1;
   localparam int STS_RUN_BIT    = 0;
   localparam int STS_FAIL_BIT   = 1;
   localparam int STS_PCOH_BIT   = 2;
   localparam int STS_SCOH_BIT   = 3;
   localparam int STS_STATE_LSB  = 8;
   localparam int ALLOC_PRX_LSB  = 0;
   localparam int ALLOC_SRX_LSB  = 4;
   localparam int ALLOC_PTX_LSB  = 8;
   localparam int ALLOC_STX_LSB  = 12;
   localparam int ERR_CFG_BIT    = 0;
   localparam int ERR_TMO_BIT    = 1;
   localparam int ERR_DROP_BIT   = 2;
   localparam logic HALF_RATE_RST = 1'b0;       // full rate after reset
   typedef enum logic [5:0] {
      ST_CAPTURE = 6'h01,
      ST_INIT    = 6'h02,
      ST_BITCAL  = 6'h04,
      ST_BYTECAL = 6'h08,
      ST_RUN     = 6'h10,
      ST_FAIL    = 6'h20
   } slp_state_t;
endpackage : slp_pkg

// ---- verilog/slp_lane_rx.sv ----
// one receive byte lane: synchronises lane clock and data, captures bytes
module slp_lane_rx (
   input  wire logic       core_clk,
   input  wire logic       rst_b,
   input  wire logic       lane_clk,
   input  wire logic [7:0] lane_data,
   output logic      [7:0] byte_out,
   output logic            byte_valid
);
   logic [8:0] sync1_ff;   // first stage, read only by sync2_ff
   logic [8:0] sync2_ff;   // second stage, safe to use
   logic       clk_prev_ff; // delayed lane clock for edge finding
   logic       rise;        // lane clock rising edge seen

   // two-flop crossing of clock and data together
   always_ff @(posedge core_clk)
   begin
      if (!rst_b)
      begin
         sync1_ff <= 9'h000;
         sync2_ff <= 9'h000;
      end
      else
      begin
         sync1_ff <= {lane_clk, lane_data};
         sync2_ff <= sync1_ff;
      end
   end

   assign rise = sync2_ff[8] & ~clk_prev_ff;

   // data is stable at the sender's rising edge, so grab it there
   always_ff @(posedge core_clk)
   begin
      if (!rst_b)
      begin
         clk_prev_ff <= 1'b0;
         byte_out    <= 8'h00;
         byte_valid  <= 1'b0;
      end
      else
      begin
         clk_prev_ff <= sync2_ff[8];
         byte_valid  <= rise;
         if (rise)
         begin
            byte_out <= sync2_ff[7:0];
         end
      end
   end
endmodule : slp_lane_rx

// ---- verilog/slp_lane_tx.sv ----
// one transmit byte lane: own clock divider, forwarded clock and byte
module slp_lane_tx #(
   parameter int HALF_CYC = slp_pkg::TX_HALF_CYC
) (
   input  wire logic       core_clk,
   input  wire logic       rst_b,
   input  wire logic       half_rate,
   input  wire logic       enable,
   input  wire logic [7:0] load_byte,
   output logic            lane_clk,
   output logic      [7:0] lane_data,
   output logic            slot
);
   logic [4:0] cnt_ff;   // half period counter
   logic       phase_ff; // free running clock phase
   logic [4:0] lim;      // last count of a half period
   logic       tick;     // half period ends

   // half rate simply doubles each half period
   assign lim  = half_rate ? 5'(2 * HALF_CYC - 1) : 5'(HALF_CYC - 1);
   // >= so that a rate switch in mid count can never run past the limit
   assign tick = (cnt_ff >= lim);
   // new byte goes out as the clock falls, mid way between rising edges
   assign slot = tick & phase_ff;

   // divider keeps running so slot timing never depends on enable
   always_ff @(posedge core_clk)
   begin
      if (!rst_b)
      begin
         cnt_ff   <= 5'h00;
         phase_ff <= 1'b0;
      end
      else
      begin
         cnt_ff <= tick ? 5'h00 : cnt_ff + 5'h01;
         if (tick)
         begin
            phase_ff <= ~phase_ff;
         end
      end
   end

   // a lane nobody owns stays quiet: clock low, idle data
   always_ff @(posedge core_clk)
   begin
      if (!rst_b)
      begin
         lane_clk  <= 1'b0;
         lane_data <= slp_pkg::IDLE_BYTE;
      end
      else
      begin
         lane_clk <= enable & (tick ? ~phase_ff : phase_ff);
         if (slot)
         begin
            lane_data <= enable ? load_byte : slp_pkg::IDLE_BYTE;
         end
      end
   end
endmodule : slp_lane_tx

// ---- verilog/slp_lane_alloc.sv ----
// lane allocator: ring capture, lane training, port routing and registers
//
// Our own choices: the address map and the plain strobed port.
module slp_lane_alloc #(
   parameter int TIMEOUT_CYC = slp_pkg::TRAIN_TIMEOUT_CYC,
   parameter int INIT_CYC    = slp_pkg::TRAIN_INIT_CYC
) (
   input  wire logic        core_clk,
   input  wire logic        rst_b,
   input  wire logic [2:0]  ring_prim_rx_cnt,
   input  wire logic [1:0]  ring_sec_rx_cnt,
   input  wire logic [2:0]  ring_prim_tx_cnt,
   input  wire logic [1:0]  ring_sec_tx_cnt,
   input  wire logic        ring_coherent,
   input  wire logic [4:0]  lane_rx_clk,
   input  wire logic [39:0] lane_rx_data,
   output logic      [4:0]  lane_tx_clk,
   output logic      [39:0] lane_tx_data,
   input  wire logic [3:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [31:0] reg_rdata,
   output logic      [31:0] prim_rx_data,
   output logic             prim_rx_valid,
   output logic      [15:0] sec_rx_data,
   output logic             sec_rx_valid,
   input  wire logic [31:0] prim_tx_data,
   input  wire logic        prim_tx_valid,
   output logic             prim_tx_ready,
   input  wire logic [15:0] sec_tx_data,
   input  wire logic        sec_tx_valid,
   output logic             sec_tx_ready,
   output logic             prim_coherent,
   output logic             link_up,
   output logic             attention
);
   localparam int NL = slp_pkg::NUM_LANES;

   slp_pkg::slp_state_t state_ff;     // training sequence state
   slp_pkg::slp_state_t nxt_state;
   logic [2:0]  prx_n_ff;             // primary receive lane count
   logic [1:0]  srx_n_ff;             // secondary receive lane count
   logic [2:0]  ptx_n_ff;             // primary transmit lane count
   logic [1:0]  stx_n_ff;             // secondary transmit lane count
   logic        half_rate_ff;         // software half rate select
   logic [15:0] timer_ff;             // time spent in current state
   logic [2:0]  err_ff;               // sticky error flags
   logic [2:0]  err_set;              // this cycle's error events
   logic        cfg_ok;               // captured counts are legal
   logic [4:0]  prx_mask;             // lanes owned per port and direction
   logic [4:0]  srx_mask;
   logic [4:0]  ptx_mask;
   logic [4:0]  stx_mask;
   logic [4:0]  rx_used;
   logic [4:0]  tx_used;
   logic [7:0]  rx_byte [NL];         // latest byte per receive lane
   logic [4:0]  rx_valid;             // byte arrival pulse per lane
   logic [3:0]  edge_cnt_ff [NL];     // bit calibration edge counts
   logic [4:0]  lock_ff;              // byte calibration pattern found
   logic [4:0]  bit_ok;
   logic        bit_done;
   logic        byte_done;
   logic        training;             // pattern is being sent
   logic        tmo;                  // calibration took too long
   logic [4:0]  tx_slot;
   logic [7:0]  tx_byte [NL];         // byte to load per transmit lane
   logic [39:0] ptx_pad;              // primary data padded to all lanes
   logic [2:0]  stx_base;             // first secondary transmit lane
   logic [2:0]  srx_base;             // first secondary receive lane
   logic [31:0] rd_mux;

   // capture takes the ring fields one edge after reset ends
   assign ptx_pad  = {slp_pkg::IDLE_BYTE, prim_tx_data};
   assign stx_base = 3'(NL) - {1'b0, stx_n_ff};
   assign srx_base = 3'(NL) - {1'b0, srx_n_ff};

   // primary counts up from lane 0, secondary down from lane 4
   generate
      for (genvar i = 0; i < NL; i++)
      begin : g_mask
         assign prx_mask[i] = 3'(i) < prx_n_ff;
         assign ptx_mask[i] = 3'(i) < ptx_n_ff;
         assign srx_mask[i] = 3'(i) >= srx_base;
         assign stx_mask[i] = 3'(i) >= stx_base;
      end
   endgenerate
   assign rx_used = prx_mask | srx_mask;
   assign tx_used = ptx_mask | stx_mask;

   // limits per port and no overlap between the two ends
   always_comb
   begin
      cfg_ok = (prx_n_ff <= 3'(slp_pkg::PRIM_MAX_LANES))
             & (srx_n_ff <= 2'(slp_pkg::SEC_MAX_LANES))
             & (ptx_n_ff <= 3'(slp_pkg::PRIM_MAX_LANES))
             & (stx_n_ff <= 2'(slp_pkg::SEC_MAX_LANES))
             & ({1'b0, prx_n_ff} + {2'b00, srx_n_ff} <= 4'(NL))
             & ({1'b0, ptx_n_ff} + {2'b00, stx_n_ff} <= 4'(NL));
   end

   // ring fields are straps: caught by a clocked capture after reset
   always_ff @(posedge core_clk)
   begin
      if (!rst_b)
      begin
         prx_n_ff <= 3'h0;
         srx_n_ff <= 2'h0;
         ptx_n_ff <= 3'h0;
         stx_n_ff <= 2'h0;
      end
      else if (state_ff == slp_pkg::ST_CAPTURE)
      begin
         prx_n_ff <= ring_prim_rx_cnt;
         srx_n_ff <= ring_sec_rx_cnt;
         ptx_n_ff <= ring_prim_tx_cnt;
         stx_n_ff <= ring_sec_tx_cnt;
      end
   end

   // receive lanes, each timed by the far end's own lane clock
   generate
      for (genvar i = 0; i < NL; i++)
      begin : g_rx
         slp_lane_rx u_rx (
            .core_clk   (core_clk),
            .rst_b      (rst_b),
            .lane_clk   (lane_rx_clk[i]),
            .lane_data  (lane_rx_data[i*8 +: 8]),
            .byte_out   (rx_byte[i]),
            .byte_valid (rx_valid[i])
         );

         // bit stage: lane must show a steady run of clock edges
         always_ff @(posedge core_clk)
         begin
            if (!rst_b)
            begin
               edge_cnt_ff[i] <= 4'h0;
               lock_ff[i]     <= 1'b0;
            end
            else
            begin
               if (state_ff == slp_pkg::ST_BITCAL && rx_valid[i] && !bit_ok[i])
               begin
                  edge_cnt_ff[i] <= edge_cnt_ff[i] + 4'h1;
               end
               // byte stage: pattern seen whole means byte framing agrees
               if (state_ff == slp_pkg::ST_BYTECAL && rx_valid[i]
                   && rx_byte[i] == slp_pkg::TRAIN_PATTERN)
               begin
                  lock_ff[i] <= 1'b1;
               end
            end
         end
         assign bit_ok[i] = edge_cnt_ff[i] >= slp_pkg::BITCAL_EDGES;
      end
   endgenerate
   assign bit_done  = &(bit_ok | ~rx_used);
   assign byte_done = &(lock_ff | ~rx_used);

   // time in state; cleared on every state change
   always_ff @(posedge core_clk)
   begin
      if (!rst_b)
      begin
         timer_ff <= 16'h0000;
      end
      else if (nxt_state != state_ff)
      begin
         timer_ff <= 16'h0000;
      end
      else if (timer_ff != 16'hffff)
      begin
         timer_ff <= timer_ff + 16'h0001;
      end
   end
   assign tmo = timer_ff >= 16'(TIMEOUT_CYC - 1);

   // training walk: init, then bit, then byte calibration
   always_comb
   begin
      nxt_state = state_ff;
      unique case (state_ff)
         slp_pkg::ST_CAPTURE: nxt_state = slp_pkg::ST_INIT;
         slp_pkg::ST_INIT:
         begin
            if (!cfg_ok)
               nxt_state = slp_pkg::ST_FAIL;
            else if (timer_ff >= 16'(INIT_CYC - 1))
               nxt_state = slp_pkg::ST_BITCAL;
         end
         slp_pkg::ST_BITCAL:
         begin
            if (bit_done)
               nxt_state = slp_pkg::ST_BYTECAL;
            else if (tmo)
               nxt_state = slp_pkg::ST_FAIL;
         end
         slp_pkg::ST_BYTECAL:
         begin
            if (byte_done)
               nxt_state = slp_pkg::ST_RUN;
            else if (tmo)
               nxt_state = slp_pkg::ST_FAIL;
         end
         slp_pkg::ST_RUN:  nxt_state = slp_pkg::ST_RUN;
         // only a reset leaves failure: lanes stay untrusted
         slp_pkg::ST_FAIL: nxt_state = slp_pkg::ST_FAIL;
         default:          nxt_state = slp_pkg::ST_FAIL;
      endcase
   end

   // state register
   always_ff @(posedge core_clk)
   begin
      if (!rst_b)
         state_ff <= slp_pkg::ST_CAPTURE;
      else
         state_ff <= nxt_state;
   end

   assign training = state_ff[1] | state_ff[2] | state_ff[3];
   assign link_up  = state_ff == slp_pkg::ST_RUN;

   // transmit lanes: pattern while training, port data once running
   generate
      for (genvar i = 0; i < NL; i++)
      begin : g_tx
         always_comb
         begin
            tx_byte[i] = slp_pkg::IDLE_BYTE;
            if (training)
               tx_byte[i] = slp_pkg::TRAIN_PATTERN;
            else if (ptx_mask[i] && prim_tx_valid)
               tx_byte[i] = ptx_pad[i*8 +: 8];
            else if (stx_mask[i] && sec_tx_valid)
               tx_byte[i] = (3'(i) != stx_base) ? sec_tx_data[15:8] : sec_tx_data[7:0];
         end
         slp_lane_tx #(
            .HALF_CYC (slp_pkg::TX_HALF_CYC)
         ) u_tx (
            .core_clk  (core_clk),
            .rst_b     (rst_b),
            .half_rate (half_rate_ff),
            .enable    (tx_used[i] & (training | link_up)),
            .load_byte (tx_byte[i]),
            .lane_clk  (lane_tx_clk[i]),
            .lane_data (lane_tx_data[i*8 +: 8]),
            .slot      (tx_slot[i])
         );
      end
   endgenerate

   // one transfer per lane clock period, only on owned lanes
   assign prim_tx_ready = link_up & tx_slot[0] & (ptx_n_ff != 3'h0);
   assign sec_tx_ready  = link_up & tx_slot[0] & (stx_n_ff != 2'h0);

   // assemble received words; lowest owned lane paces each port
   always_ff @(posedge core_clk)
   begin
      if (!rst_b)
      begin
         prim_rx_data  <= 32'h0000_0000;
         prim_rx_valid <= 1'b0;
         sec_rx_data   <= 16'h0000;
         sec_rx_valid  <= 1'b0;
      end
      else
      begin
         prim_rx_valid <= link_up & rx_valid[0] & prx_mask[0];
         if (rx_valid[0])
            prim_rx_data <= {rx_byte[3] & {8{prx_mask[3]}}, rx_byte[2] & {8{prx_mask[2]}},
                             rx_byte[1] & {8{prx_mask[1]}}, rx_byte[0]};
         sec_rx_valid <= link_up & (srx_n_ff == 2'h2 ? rx_valid[3]
                                   : (srx_n_ff == 2'h1 && rx_valid[4]));
         if (srx_n_ff == 2'h2)
            sec_rx_data <= {rx_byte[4], rx_byte[3]};
         else
            sec_rx_data <= {8'h00, rx_byte[4]};
      end
   end

   // primary protocol: ring value first, software may change it later
   always_ff @(posedge core_clk)
   begin
      if (!rst_b)
      begin
         prim_coherent <= 1'b0;
         half_rate_ff  <= slp_pkg::HALF_RATE_RST;
      end
      else if (state_ff == slp_pkg::ST_CAPTURE)
      begin
         prim_coherent <= ring_coherent;
      end
      else if (reg_wr && reg_addr == slp_pkg::ADDR_CTRL)
      begin
         prim_coherent <= reg_wdata[slp_pkg::CTRL_COH_BIT];
         half_rate_ff  <= reg_wdata[slp_pkg::CTRL_HALF_BIT];
      end
   end

   // error events; a new event outranks a clear in the same cycle
   always_comb
   begin
      err_set = 3'h0;
      err_set[slp_pkg::ERR_CFG_BIT]  = (state_ff == slp_pkg::ST_INIT) & ~cfg_ok;
      err_set[slp_pkg::ERR_TMO_BIT]  = (state_ff == slp_pkg::ST_BITCAL & ~bit_done & tmo)
                                     | (state_ff == slp_pkg::ST_BYTECAL & ~byte_done & tmo);
      err_set[slp_pkg::ERR_DROP_BIT] = ~link_up & (prim_tx_valid | sec_tx_valid);
   end

   // sticky flags, write one to clear; attention follows them
   always_ff @(posedge core_clk)
   begin
      if (!rst_b)
      begin
         err_ff    <= 3'h0;
         attention <= 1'b0;
      end
      else
      begin
         if (reg_wr && reg_addr == slp_pkg::ADDR_ERR)
            err_ff <= (err_ff & ~reg_wdata[2:0]) | err_set;
         else
            err_ff <= err_ff | err_set;
         attention <= |err_ff;
      end
   end

   // read mux; secondary coherent bit is hard zero
   always_comb
   begin
      rd_mux = 32'h0000_0000;
      unique case (reg_addr)
         slp_pkg::ADDR_CTRL:
         begin
            rd_mux[slp_pkg::CTRL_COH_BIT]  = prim_coherent;
            rd_mux[slp_pkg::CTRL_HALF_BIT] = half_rate_ff;
         end
         slp_pkg::ADDR_STATUS:
         begin
            rd_mux[slp_pkg::STS_RUN_BIT]  = link_up;
            rd_mux[slp_pkg::STS_FAIL_BIT] = state_ff == slp_pkg::ST_FAIL;
            rd_mux[slp_pkg::STS_PCOH_BIT] = prim_coherent;
            rd_mux[slp_pkg::STS_SCOH_BIT] = 1'b0;
            rd_mux[slp_pkg::STS_STATE_LSB +: 6] = state_ff;
         end
         slp_pkg::ADDR_ALLOC:
         begin
            rd_mux[slp_pkg::ALLOC_PRX_LSB +: 3] = prx_n_ff;
            rd_mux[slp_pkg::ALLOC_SRX_LSB +: 2] = srx_n_ff;
            rd_mux[slp_pkg::ALLOC_PTX_LSB +: 3] = ptx_n_ff;
            rd_mux[slp_pkg::ALLOC_STX_LSB +: 2] = stx_n_ff;
         end
         slp_pkg::ADDR_ERR: rd_mux[2:0] = err_ff;
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   // read data stands only in the cycle after the strobe
   always_ff @(posedge core_clk)
   begin
      if (!rst_b)
         reg_rdata <= 32'h0000_0000;
      else
         reg_rdata <= reg_rd ? rd_mux : 32'h0000_0000;
   end

   // checks; the control logic itself uses one clock (core_clk)
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_b);

   property p_sec_noncoh;
      reg_rd && reg_addr == slp_pkg::ADDR_STATUS |=> !reg_rdata[slp_pkg::STS_SCOH_BIT];
   endproperty
   a_sec_noncoh: assert property (p_sec_noncoh) else $error("secondary shows coherent");

   property p_coh_write;
      reg_wr && reg_addr == slp_pkg::ADDR_CTRL && state_ff != slp_pkg::ST_CAPTURE
         |=> prim_coherent == $past(reg_wdata[slp_pkg::CTRL_COH_BIT]);
   endproperty
   a_coh_write: assert property (p_coh_write) else $error("coherency write lost");

   property p_idle_lane;
      !tx_used[4] && state_ff != slp_pkg::ST_CAPTURE |=> !lane_tx_clk[4];
   endproperty
   a_idle_lane: assert property (p_idle_lane) else $error("unowned lane clocked");

   // rate must hold through the high time; a switch in mid period is legal
   property p_full_rate;
      $rose(lane_tx_clk[0]) && !half_rate_ff ##1 !half_rate_ff [*3]
         |-> ($past(lane_tx_clk[0], 2) && $past(lane_tx_clk[0]) && lane_tx_clk[0])
         ##1 !lane_tx_clk[0];
   endproperty
   a_full_rate: assert property (p_full_rate) else $error("lane clock high time");

   property p_stage_order;
      state_ff == slp_pkg::ST_BITCAL |=> state_ff inside {slp_pkg::ST_BITCAL,
         slp_pkg::ST_BYTECAL, slp_pkg::ST_FAIL};
   endproperty
   a_stage_order: assert property (p_stage_order) else $error("training order");

   property p_capture;
      state_ff == slp_pkg::ST_CAPTURE |=> prx_n_ff == $past(ring_prim_rx_cnt)
         && stx_n_ff == $past(ring_sec_tx_cnt);
   endproperty
   a_capture: assert property (p_capture) else $error("ring fields not captured");

   property p_run_limits;
      link_up |-> prx_n_ff <= 3'h4 && srx_n_ff <= 2'h2 && ptx_n_ff <= 3'h4;
   endproperty
   a_run_limits: assert property (p_run_limits) else $error("illegal count running");

   property p_no_overlap;
      link_up |-> (prx_mask & srx_mask) == 5'h00 && (ptx_mask & stx_mask) == 5'h00;
   endproperty
   a_no_overlap: assert property (p_no_overlap) else $error("lane overlap");

   property p_attention;
      err_set != 3'h0 |-> ##[1:2] attention;
   endproperty
   a_attention: assert property (p_attention) else $error("error without attention");

   c_run:   cover property ($rose(link_up));
   c_fail:  cover property (state_ff == slp_pkg::ST_FAIL);
   c_prx:   cover property (prim_rx_valid);
   c_ptx:   cover property (prim_tx_valid && prim_tx_ready);
endmodule : slp_lane_alloc

// ---- bench/slp_far_end.sv ----
// far-end lane model: forwarded clock and bytes on the five receive lanes
module slp_far_end (
   input  wire logic        en,
   input  wire logic [39:0] pat,
   output logic      [4:0]  lane_rx_clk,
   output logic      [39:0] lane_rx_data
);
   timeunit 1ns;
   timeprecision 1ns;
   // all lanes clocked together, bytes change as the clock falls
   initial
   begin
      lane_rx_clk = 5'h00;
      lane_rx_data = 40'h0;
      forever
      begin
         // idle lanes toggle their data so stale bytes never look valid
         #400 lane_rx_data = en ? pat : ~lane_rx_data;
         lane_rx_clk = 5'h00;
         #400 lane_rx_clk = {5{en}};
      end
   end
endmodule : slp_far_end

// ---- bench/tb_top.sv ----
// self-checking bench for the lane allocator
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic        core_clk, rst_b, en, rwr, rrd, coh, pval, sval, pcoh, up, att;
   logic        ptv, rdy;
   logic [2:0]  prx;
   logic [1:0]  srx;
   logic [3:0]  addr;
   logic [31:0] wd, rdata, pdata, ptd;
   logic [15:0] sdata;
   logic [39:0] pat, rxd, txd;
   logic [4:0]  rxc, txc;
   int          n_mismatch, samples_checked, i;
   slp_far_end i_far (.en(en), .pat(pat), .lane_rx_clk(rxc), .lane_rx_data(rxd));
   slp_lane_alloc #(.TIMEOUT_CYC(2000), .INIT_CYC(20)) i_dut (
      .core_clk(core_clk), .rst_b(rst_b), .ring_prim_rx_cnt(prx), .ring_sec_rx_cnt(srx),
      .ring_prim_tx_cnt(prx), .ring_sec_tx_cnt(srx), .ring_coherent(coh),
      .lane_rx_clk(rxc), .lane_rx_data(rxd), .lane_tx_clk(txc), .lane_tx_data(txd),
      .reg_addr(addr), .reg_wdata(wd), .reg_wr(rwr), .reg_rd(rrd), .reg_rdata(rdata),
      .prim_rx_data(pdata), .prim_rx_valid(pval), .sec_rx_data(sdata), .sec_rx_valid(sval),
      .prim_tx_data(ptd), .prim_tx_valid(ptv), .prim_tx_ready(rdy),
      .sec_tx_data(16'h0), .sec_tx_valid(1'b0), .sec_tx_ready(),
      .prim_coherent(pcoh), .link_up(up), .attention(att));
   initial
   begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end
   task summarize;
      $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : summarize
   task chk(input logic [31:0] s, input logic [31:0] e);
      samples_checked++;
      if (s !== e)
      begin
         n_mismatch++;
         $display("Error %0t: got %h want %h", $time, s, e);
      end
   endtask : chk
   // bounded wait, sampled on the falling edge
   task wait_for(input logic [1:0] which);
      for (i = 0; i < 3000; i++)
      begin
         @(negedge core_clk);
         if ((which == 2'h2 ? rdy : which[0] ? pval : up) === 1'b1)
            return;
      end
      n_mismatch++;
      summarize();
   endtask : wait_for
   task wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge core_clk);
      addr <= a;
      wd <= d;
      rwr <= 1'b1;
      @(posedge core_clk);
      rwr <= 1'b0;
   endtask : wr
   task rd(input logic [3:0] a, input logic [31:0] e);
      @(posedge core_clk);
      addr <= a;
      rrd <= 1'b1;
      @(posedge core_clk);
      rrd <= 1'b0;
      @(negedge core_clk);
      chk(rdata, e);
   endtask : rd
   // reset with given straps; outputs checked quiet once, after three reset cycles
   task reset_dut(input logic [2:0] p, input logic [1:0] s);
      @(posedge core_clk);
      rst_b <= 1'b0;
      prx <= p;
      srx <= s;
      repeat (3) @(posedge core_clk);
      chk({up, att, txc}, 32'h0);
      rst_b <= 1'b1;
      @(posedge core_clk);
   endtask : reset_dut
   task t_train;
      reset_dut(3'h3, 2'h2);
      wait_for(2'h0);
      rd(4'h1, 32'h1005);
      rd(4'h2, 32'h2323);
      $display("training done");
   endtask : t_train
   task t_rx;
      pat <= 40'h5544332211;
      wait_for(2'h1);
      wait_for(2'h1);
      chk({30'h0, pval, sval}, 32'h3);
      chk(pdata, 32'h00332211);
      chk({16'h0, sdata}, 32'h5544);
      $display("receive done");
   endtask : t_rx
   // ready pulses one lane period apart, then the word out on the lanes
   task t_tx(input logic h);
      wr(4'h0, {30'h0, h, 1'b1});
      ptd <= 32'hc3b2a190;
      ptv <= 1'b1;
      wait_for(2'h2);
      i = 0;
      do
      begin
         @(negedge core_clk);
         i++;
      end
      while (rdy !== 1'b1 && i < 40);
      chk(i, (h ? 4 : 2) * slp_pkg::TX_HALF_CYC);
      @(negedge core_clk);
      chk(txd[31:0], 32'h00b2a190);
      chk({19'h0, txc, txd[39:32]}, 32'h0);
      @(posedge core_clk);
      ptv <= 1'b0;
      $display("transmit done");
   endtask : t_tx
   task t_regs;
      wr(4'h0, 32'h0);
      rd(4'h1, 32'h1001);
      chk({31'h0, pcoh}, 32'h0);
      rd(4'h9, 32'h0);
      rd(4'h3, 32'h0);
      $display("registers done");
   endtask : t_regs
   task t_bad;
      en <= 1'b0;
      reset_dut(3'h4, 2'h2);
      repeat (40) @(posedge core_clk);
      chk({31'h0, att}, 32'h1);
      rd(4'h3, 32'h1);
      rd(4'h1, 32'h2006);
      $display("bad config done");
   endtask : t_bad
   initial
   begin
      rst_b = 1'b0;
      en = 1'b1;
      coh = 1'b1;
      rwr = 1'b0;
      rrd = 1'b0;
      addr = 4'h0;
      wd = 32'h0;
      ptd = 32'h0;
      ptv = 1'b0;
      prx = 3'h3;
      srx = 2'h2;
      pat = 40'ha5a5a5a5a5;
      n_mismatch = 0;
      samples_checked = 0;
      t_train();
      t_rx();
      t_tx(1'b0);
      t_tx(1'b1);
      t_regs();
      t_bad();
      summarize();
   end
endmodule : tb_top
